// File: design/sccr_map.svh
`ifndef SCCR_MAP_SVH
`define SCCR_MAP_SVH

// -----------------------------------------------------------------------------
// Register offsets (byte addresses)
// -----------------------------------------------------------------------------
`define SCCR_OFS_SETUP 12'h000
`define SCCR_OFS_UPDATE 12'h008
`define SCCR_OFS_ACTIVE 12'h00c
`define SCCR_ADDR_W 12

// -----------------------------------------------------------------------------
// Reset values and field positions
// -----------------------------------------------------------------------------
`define SCCR_SETUP_RESET 32'h0cc0_0000
`define SCCR_RSVD_BIT 19
`define SCCR_APPLY_BIT 0
`define SCCR_IN_DIV_LSB 8
`define SCCR_IN_DIV_W 5

// -----------------------------------------------------------------------------
// Divider codes and ratios
// -----------------------------------------------------------------------------
`define SCCR_CORE_DIV_12 4'hc
`define SCCR_CORE_DIV_10 4'ha
`define SCCR_CORE_DIV_8 4'h8
`define SCCR_CORE_DIV_6 4'h6
`define SCCR_CORE_DIV_4 4'h4
`define SCCR_CORE_DIV_3 4'h3
`define SCCR_CORE_DIV_2 4'h2
`define SCCR_RATIO_1 3'h1
`define SCCR_RATIO_2 3'h2
`define SCCR_RATIO_3 3'h3
`define SCCR_RATIO_4 3'h4

// -----------------------------------------------------------------------------
// Bus responses
// -----------------------------------------------------------------------------
`define SCCR_RESP_OKAY 2'h0
`define SCCR_RESP_SLVERR 2'h2

`endif

// File: design/sccr_pkg.sv
package sccr_pkg;

  // ---------------------------------------------------------------------------
  // Setup register layout, bit 31 first
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] secondary_core_bus_ratio;
    logic tcm_select;
    logic [2:0] secondary_core_clock_divider;
    logic source_select;
    logic [2:0] primary_core_clock_divider;
    logic [1:0] sys_clock_ratio;
    logic reserved_19;
    logic [2:0] pll_band;
    logic [2:0] pll_output_divider;
    logic [4:0] pll_input_divider;
    logic [7:0] pll_feedback_divider;
  } sccr_setup_t;

  // ---------------------------------------------------------------------------
  // Decoded divide ratios for the clock generators
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] primary_core_div;
    logic [3:0] secondary_core_div;
    logic [2:0] sys_div;
    logic [2:0] secondary_bus_div;
  } sccr_ratio_t;

  typedef enum logic [0:0] {
    SCCR_SRC_SYSTEM_PLL = 1'b0,
    SCCR_SRC_AUXILIARY_PLL = 1'b1
  } sccr_src_t;

endpackage : sccr_pkg

// File: design/sccr_clk_en_gen.sv
`timescale 1ns/10ps
`include "sccr_map.svh"

module sccr_clk_en_gen
  import sccr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Ratio, 1 to 4
  input wire logic [2:0] ratio,
  // Enable pulse, one cycle in every ratio cycles
  output logic clk_en
);

  logic [2:0] count_r;
  logic [2:0] count_nxt;
  logic clk_en_r;
  logic wrap;

  // Ratio change restarts cleanly at the next wrap, no short pulse
  assign wrap = (count_r >= (ratio - 3'h1));
  assign count_nxt = wrap ? 3'h0 : (count_r + 3'h1);
  assign clk_en = clk_en_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= 3'h0;
      clk_en_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      clk_en_r <= wrap;
    end
  end

endmodule : sccr_clk_en_gen

// File: design/sccr_top.sv
`timescale 1ns/10ps
`include "sccr_map.svh"


module sccr_top
  import sccr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Power-up straps from the external address bus
  input wire logic [4:0] strap_pll_input_divider,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Applied clock setup
  output sccr_setup_t active_setup,
  output sccr_ratio_t active_ratio,
  output logic pll_source_auxiliary,
  output logic tcm_as_coupled_memory,
  output logic apply_pulse,
  // Clock enables
  output logic sys_clk_en,
  output logic secondary_bus_clk_en
);

  // ---------------------------------------------------------------------------
  // Decode functions
  // ---------------------------------------------------------------------------
  function automatic logic [3:0] core_div_ratio(input logic [2:0] code);
    logic [3:0] r;
    r = `SCCR_CORE_DIV_12;
    unique case (code)
      3'h1: r = `SCCR_CORE_DIV_2;
      3'h2: r = `SCCR_CORE_DIV_3;
      3'h3: r = `SCCR_CORE_DIV_4;
      3'h4: r = `SCCR_CORE_DIV_6;
      3'h5: r = `SCCR_CORE_DIV_8;
      3'h6: r = `SCCR_CORE_DIV_10;
      3'h0, 3'h7: r = `SCCR_CORE_DIV_12;
    endcase
    return r;
  endfunction : core_div_ratio

  function automatic logic [2:0] sys_div_ratio(input logic [1:0] code);
    logic [2:0] r;
    r = `SCCR_RATIO_1;
    unique case (code)
      2'h3: r = `SCCR_RATIO_4;
      2'h2: r = `SCCR_RATIO_3;
      2'h1: r = `SCCR_RATIO_2;
      2'h0: r = `SCCR_RATIO_1;
    endcase
    return r;
  endfunction : sys_div_ratio

  // Code 01 is not defined for the bus ratio; it is taken as equal clocks
  function automatic logic [2:0] bus_div_ratio(input logic [1:0] code);
    logic [2:0] r;
    r = `SCCR_RATIO_1;
    unique case (code)
      2'h3: r = `SCCR_RATIO_4;
      2'h2: r = `SCCR_RATIO_2;
      2'h1, 2'h0: r = `SCCR_RATIO_1;
    endcase
    return r;
  endfunction : bus_div_ratio

  // Byte lanes without a strobe keep their old contents
  function automatic logic [31:0] strobe_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : strobe_merge

  // ---------------------------------------------------------------------------
  // Bus decode functions
  // ---------------------------------------------------------------------------
  // Only the word part of the address counts; byte lanes are ignored
  function automatic logic word_hit(input logic [11:0] addr, input logic [11:0] ofs);
    return addr[11:2] == ofs[11:2];
  endfunction : word_hit

  function automatic logic [1:0] resp_code(input logic mapped);
    return mapped ? `SCCR_RESP_OKAY : `SCCR_RESP_SLVERR;
  endfunction : resp_code

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  // Programmed and applied setup
  sccr_setup_t setup_r;
  sccr_setup_t setup_nxt;
  sccr_setup_t active_r;
  sccr_setup_t active_nxt;
  sccr_ratio_t ratio_r;
  sccr_ratio_t ratio_nxt;
  logic strap_done_r;
  logic apply_r;

  // Write channel
  logic awready_r;
  logic wready_r;
  logic aw_held_r;
  logic w_held_r;
  logic [11:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  // Read channel
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // ---------------------------------------------------------------------------
  // Write path
  // ---------------------------------------------------------------------------
  wire aw_fire = s_axi_awvalid && awready_r;
  wire w_fire = s_axi_wvalid && wready_r;
  // Commit waits for both channels, which may arrive in either order
  wire wr_commit = aw_held_r && w_held_r && !bvalid_r;
  wire wr_hit_setup = word_hit(waddr_r, `SCCR_OFS_SETUP);
  wire wr_hit_update = word_hit(waddr_r, `SCCR_OFS_UPDATE);
  wire wr_hit_active = word_hit(waddr_r, `SCCR_OFS_ACTIVE);
  wire wr_mapped = wr_hit_setup || wr_hit_update || wr_hit_active;
  wire b_fire = bvalid_r && s_axi_bready;
  wire update_req = wstrb_r[0] && wdata_r[`SCCR_APPLY_BIT];
  wire apply_now = wr_commit && wr_hit_update && update_req;
  wire [31:0] setup_merged = strobe_merge(setup_r, wdata_r, wstrb_r);
  // Straps land one cycle after reset, before any write can commit
  wire strap_now = !strap_done_r;

  always_comb begin
    setup_nxt = setup_r;
    if (strap_now) begin
      setup_nxt.pll_input_divider = strap_pll_input_divider;
    end else if (wr_commit && wr_hit_setup) begin
      setup_nxt = setup_merged;
    end
    setup_nxt.reserved_19 = 1'b0;
  end

  // Setup writes never reach the clock generators directly
  always_comb begin
    active_nxt = active_r;
    if (strap_now) begin
      active_nxt.pll_input_divider = strap_pll_input_divider;
    end else if (apply_now) begin
      active_nxt = setup_r;
    end
    active_nxt.reserved_19 = 1'b0;
  end

  always_comb begin
    ratio_nxt.primary_core_div = core_div_ratio(active_r.primary_core_clock_divider);
    ratio_nxt.secondary_core_div = core_div_ratio(active_r.secondary_core_clock_divider);
    ratio_nxt.sys_div = sys_div_ratio(active_r.sys_clock_ratio);
    ratio_nxt.secondary_bus_div = bus_div_ratio(active_r.secondary_core_bus_ratio);
  end

  // ---------------------------------------------------------------------------
  // Setup and applied registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_r <= `SCCR_SETUP_RESET;
      active_r <= `SCCR_SETUP_RESET;
      ratio_r <= '0;
      strap_done_r <= 1'b0;
      apply_r <= 1'b0;
    end else begin
      setup_r <= setup_nxt;
      active_r <= active_nxt;
      ratio_r <= ratio_nxt;
      strap_done_r <= 1'b1;
      apply_r <= apply_now;
    end
  end

  // ---------------------------------------------------------------------------
  // Write channel handshakes
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= `SCCR_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        awready_r <= 1'b0;
        aw_held_r <= 1'b1;
        waddr_r <= s_axi_awaddr;
      end
      if (w_fire) begin
        wready_r <= 1'b0;
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_commit) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= resp_code(wr_mapped);
      end
      // Ready again only once the response is gone: one write at a time
      if (b_fire) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  wire ar_fire = s_axi_arvalid && arready_r;
  wire r_fire = rvalid_r && s_axi_rready;
  wire rd_hit_setup = word_hit(s_axi_araddr, `SCCR_OFS_SETUP);
  wire rd_hit_update = word_hit(s_axi_araddr, `SCCR_OFS_UPDATE);
  wire rd_hit_active = word_hit(s_axi_araddr, `SCCR_OFS_ACTIVE);
  wire rd_mapped = rd_hit_setup || rd_hit_update || rd_hit_active;
  // The update register is a strobe and reads back zero
  wire [31:0] rd_word = rd_hit_setup ? setup_r : (rd_hit_active ? active_r : 32'h0000_0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `SCCR_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= resp_code(rd_mapped);
      end
      if (r_fire) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Clock enables
  // ---------------------------------------------------------------------------
  // Slot 0 paces the system clock for the shared logic, slot 1 the bus enable
  // of the secondary core; neither changes the other
  // A ratio change waits for the next wrap, so one period may stretch
  logic [2:0] en_ratio [2];
  logic [1:0] en_pulse;

  assign en_ratio[0] = ratio_r.sys_div;
  assign en_ratio[1] = ratio_r.secondary_bus_div;

  for (genvar g = 0; g < 2; g++) begin : g_en
    sccr_clk_en_gen u_en (
      .aclk(aclk),
      .aresetn(aresetn),
      .ratio(en_ratio[g]),
      .clk_en(en_pulse[g])
    );
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Register bus
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Applied setup
  assign active_setup = active_r;
  assign active_ratio = ratio_r;
  assign pll_source_auxiliary = active_r.source_select;
  assign tcm_as_coupled_memory = active_r.tcm_select;
  assign apply_pulse = apply_r;

  // Clock enables
  assign sys_clk_en = en_pulse[0];
  assign secondary_bus_clk_en = en_pulse[1];

endmodule : sccr_top

// File: bench/sccr_chk.sv
`timescale 1ns/10ps
module sccr_chk
  import sccr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Read handshake
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Applied setup and enables
  input wire sccr_setup_t active_setup,
  input wire sccr_ratio_t active_ratio,
  input wire logic pll_source_auxiliary,
  input wire logic tcm_as_coupled_memory,
  input wire logic apply_pulse,
  input wire logic sys_clk_en,
  input wire logic secondary_bus_clk_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic [3:0] core_div(input logic [2:0] c);
    case (c)
      3'h1: return 4'h2;
      3'h2: return 4'h3;
      3'h3: return 4'h4;
      3'h4: return 4'h6;
      3'h5: return 4'h8;
      3'h6: return 4'ha;
      default: return 4'hc;
    endcase
  endfunction : core_div

  a_rsvd_zero: assert property (active_setup.reserved_19 == 1'b0)
    else $error("reserved bit set in applied setup");
  // Strap load right after reset is the one change without apply
  a_apply_only: assert property ($changed(active_setup) && $past(aresetn, 2) |-> apply_pulse)
    else $error("applied setup changed without apply");
  a_src_sel: assert property (apply_pulse || $changed(pll_source_auxiliary) |->
    apply_pulse && pll_source_auxiliary == active_setup.source_select)
    else $error("source select mismatch");
  a_tcm_sel: assert property (apply_pulse || $changed(tcm_as_coupled_memory) |->
    apply_pulse && tcm_as_coupled_memory == active_setup.tcm_select)
    else $error("memory role mismatch");
  a_sec_div: assert property (apply_pulse |=>
    active_ratio.secondary_core_div == core_div(active_setup.secondary_core_clock_divider))
    else $error("secondary divide mismatch");
  a_pri_div: assert property (apply_pulse |=>
    active_ratio.primary_core_div == core_div(active_setup.primary_core_clock_divider))
    else $error("primary divide mismatch");
  a_sys_div: assert property (apply_pulse |=>
    active_ratio.sys_div == {1'b0, active_setup.sys_clock_ratio} + 3'h1)
    else $error("system ratio mismatch");
  a_bus_div: assert property (apply_pulse |=> active_ratio.secondary_bus_div ==
    (active_setup.secondary_core_bus_ratio == 2'h3 ? 3'h4 :
     active_setup.secondary_core_bus_ratio == 2'h2 ? 3'h2 : 3'h1))
    else $error("bus ratio mismatch");
  // Pacing is judged only while the ratio holds for the whole period
  a_sys_pace: assert property (sys_clk_en && active_ratio.sys_div == 3'h3 ##1
    (active_ratio.sys_div == 3'h3) [*2] |=> sys_clk_en && !$past(sys_clk_en) && !$past(sys_clk_en, 2))
    else $error("system enable pacing wrong");
  a_bus_pace: assert property (secondary_bus_clk_en && active_ratio.secondary_bus_div == 3'h2 ##1
    active_ratio.secondary_bus_div == 3'h2 |=> secondary_bus_clk_en && !$past(secondary_bus_clk_en))
    else $error("bus enable pacing wrong");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");

  c_apply: cover property (apply_pulse);
  c_sys4: cover property (sys_clk_en && active_ratio.sys_div == 3'h4);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : sccr_chk

bind sccr_top sccr_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .active_setup(active_setup), .active_ratio(active_ratio), .pll_source_auxiliary(pll_source_auxiliary),
  .tcm_as_coupled_memory(tcm_as_coupled_memory), .apply_pulse(apply_pulse), .sys_clk_en(sys_clk_en),
  .secondary_bus_clk_en(secondary_bus_clk_en));

// File: bench/sccr_top_tb.sv
`timescale 1ns/10ps
module sccr_top_tb;
  import sccr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] strap_pll_input_divider = 5'h15;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  sccr_setup_t active_setup;
  sccr_ratio_t active_ratio;
  logic pll_source_auxiliary, tcm_as_coupled_memory, apply_pulse, sys_clk_en, secondary_bus_clk_en;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int n_apply = 0;
  logic [3:0] cd [8] = '{4'hc, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc};
  logic [2:0] bd [4] = '{3'h1, 3'h1, 3'h2, 3'h4};

  sccr_top dut (.aclk(aclk), .aresetn(aresetn), .strap_pll_input_divider(strap_pll_input_divider),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .active_setup(active_setup),
    .active_ratio(active_ratio), .pll_source_auxiliary(pll_source_auxiliary),
    .tcm_as_coupled_memory(tcm_as_coupled_memory), .apply_pulse(apply_pulse),
    .sys_clk_en(sys_clk_en), .secondary_bus_clk_en(secondary_bus_clk_en));

  always #4 aclk = ~aclk;

  // Apply pulse lasts one cycle and is over before a write task returns
  always @(negedge aclk) n_apply += int'(apply_pulse);

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Handshakes are judged at the falling edge, where ready is settled
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb, done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid & s_axi_bready;
      if (tb) chk({30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      done = tb;
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr, done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid & s_axi_rready;
      if (tr) chk(s_axi_rdata, ed);
      if (tr) chk({30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      done = tr;
    end
  endtask : rd

  task automatic apply();
    int n0;
    n0 = n_apply;
    wr(12'h008, 32'h1, 2'h0);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(32'(n_apply - n0), 32'h1);
  endtask : apply

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      print_verdict();
    end
  end

  // -------------------------------------------------------------------------
  // Sequence
  // -------------------------------------------------------------------------
  initial begin
    logic [31:0] w;
    int ns, nb;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    @(negedge aclk);
    chk(active_setup, 32'h0cc0_1500);
    rd(12'h000, 32'h0cc0_1500, 2'h0);
    wr(12'h000, 32'hffff_ffff, 2'h0);
    rd(12'h000, 32'hfff7_ffff, 2'h0);
    s_axi_wstrb <= 4'h1;
    wr(12'h000, 32'h0, 2'h0);
    s_axi_wstrb <= 4'he;
    wr(12'h008, 32'h1, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(12'h000, 32'hfff7_ff00, 2'h0);
    wr(12'h008, 32'h0, 2'h0);
    chk(32'(n_apply), 32'h0);
    @(negedge aclk);
    chk(active_setup, 32'h0cc0_1500);
    chk({31'h0, pll_source_auxiliary}, 32'h0);
    rd(12'h00c, 32'h0cc0_1500, 2'h0);
    rd(12'h008, 32'h0, 2'h0);
    wr(12'h010, 32'h1234_5678, 2'h2);
    rd(12'h010, 32'h0, 2'h2);
    // Every divider code, with both select bits toggling
    for (int k = 0; k < 8; k++) begin
      w = {k[1:0], k[0], k[2:0], k[1], 3'(7 - k), k[1:0], 1'b0, k[2:0], k[2:0], 5'(k), 8'(k)};
      wr(12'h000, w, 2'h0);
      rd(12'h000, w, 2'h0);
      apply();
      chk(active_setup, w);
      chk({18'h0, active_ratio}, {18'h0, cd[7 - k], cd[k], 3'(k % 4 + 1), bd[k % 4]});
      chk({31'h0, pll_source_auxiliary}, {31'h0, k[1]});
      chk({31'h0, tcm_as_coupled_memory}, {31'h0, k[0]});
      wr(12'h00c, 32'h0, 2'h0);
      rd(12'h00c, w, 2'h0);
      repeat (8) @(negedge aclk);
      ns = 0;
      nb = 0;
      repeat (24) begin
        @(negedge aclk);
        ns += int'(sys_clk_en);
        nb += int'(secondary_bus_clk_en);
      end
      chk(32'(ns), 32'(24 / (k % 4 + 1)));
      chk(32'(nb), 32'(24 / int'(bd[k % 4])));
    end
    print_verdict();
  end
endmodule : sccr_top_tb
